/* verilog/ldi_pkg.sv */
// Purpose: Shared constants for the LCD driver data input block
// Assumes: One system clock; all pin inputs are asynchronous to it
// Notes:   Counts are in pixels, bus words and latch slots

package ldi_pkg;

	localparam int unsigned NUM_OUTPUTS  = 160; // Drive outputs per chip
	localparam int unsigned HALF_OUTPUTS = 80;  // Half register in dual mode
	localparam int unsigned BUS_WIDTH    = 8;   // Internal data bus word
	localparam int unsigned NIBBLE_WIDTH = 4;   // Narrow input word
	localparam int unsigned SLOT_COUNT   = NUM_OUTPUTS / BUS_WIDTH;
	localparam int unsigned FIFO_DEPTH   = 4;   // Words between capture and latch
	localparam int unsigned SYNC_STAGES  = 3;   // Flops on clock, latch, cascade and data pins

	// Reset values
	localparam logic       ENABLE_IDLE   = 1'b1; // Cascade enable rests high
	localparam logic [4:0] SLOT_RESET    = 5'h00;

	localparam int unsigned CLK_PERIOD_NS = 20; // 50 MHz system clock

endpackage : ldi_pkg

/* verilog/ldi_fifo.sv */
// Purpose: Small word FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Read data come from a register; full and empty are exact
`timescale 1ns/1ns

module ldi_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               cnt;
		logic [WIDTH-1:0]            dout;
		logic                        dval;
	} ldi_fifo_s;

	ldi_fifo_s st_q, st_d;
	logic      push, pop, load;

	// Output register counts as one slot so full stays honest
	assign in_ready  = (st_q.cnt != CW'(DEPTH));
	assign out_valid = st_q.dval;
	assign out_data  = st_q.dout;
	assign push      = in_valid & in_ready;
	assign pop       = st_q.dval & out_ready;

	// Next state: store, then refill the output register when it frees
	always_comb begin
		st_d = st_q;
		load = 1'b0;
		if (push) begin
			st_d.mem[st_q.wr] = in_data;
			st_d.wr = (st_q.wr == PW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
		end
		if ((!st_q.dval || pop) && (st_q.cnt > CW'(st_q.dval))) begin
			load = 1'b1;
			st_d.dout = st_q.mem[st_q.rd];
			st_d.rd = (st_q.rd == PW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
		end
		st_d.dval = load ? 1'b1 : (pop ? 1'b0 : st_q.dval);
		st_d.cnt  = st_q.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule : ldi_fifo

/* verilog/ldi_input.sv */
// Purpose: Pixel data input, cascade select and common shift register
// Assumes: Pins are sampled on CLK; pixel clock well below CLK / 4
// Notes:   Segment data pass through a FIFO before the data latch
//
// How it works
// - WIDTH_SELECT picks four-bit or eight-bit pixel words in segment mode.
// - Capture stops by itself once 160 bits have been taken in.
// - Common mode has a 160-bit shift register, or two 80-bit halves.
// - Four shift directions from SHIFT_DIR and DUAL_MODE pins.
// - After line latch pulse, low enable-in selects chip until 160 bits.
// - At 160 bits, enable goes to next chip and this chip deselects.
// - SHIFT_DIR makes one cascade port input, the other output.
// - Two nibbles or one byte become one 8-bit bus word.
// - Bus words fill latch slots in the order set by SHIFT_DIR.
// - Pixel data sampled on falling edge of pixel shift clock.
// - Line latch pulse falling edge copies all 160 bits to drive latch.
// - Enable out high, low for one pixel clock after 160th bit.
`timescale 1ns/1ns

module ldi_input
	import ldi_pkg::*;
#(
	parameter int unsigned OUTPUTS = NUM_OUTPUTS,
	parameter int unsigned DEPTH   = FIFO_DEPTH
) (
	input  wire logic               CLK,
	input  wire logic               SYS_RST,
	input  wire logic               SEG_MODE,
	input  wire logic               SHIFT_DIR,
	input  wire logic               DUAL_MODE,
	input  wire logic               WIDTH_SELECT,
	input  wire logic               PIXEL_SHIFT_CLOCK,
	input  wire logic               LINE_LATCH_PULSE,
	input  wire logic [7:0]         PIXEL_DATA_IN,
	input  wire logic               CASCADE_PORT_FIRST_I,
	output logic                    CASCADE_PORT_FIRST_O,
	output logic                    CASCADE_PORT_FIRST_OE_N,
	input  wire logic               CASCADE_PORT_SECOND_I,
	output logic                    CASCADE_PORT_SECOND_O,
	output logic                    CASCADE_PORT_SECOND_OE_N,
	output logic [OUTPUTS-1:0]      DRIVE_OUTPUTS
);

	localparam int unsigned HALF  = OUTPUTS / 2;
	localparam int unsigned SLOTS = OUTPUTS / BUS_WIDTH;

	// Pin bundle run through the synchroniser as one vector
	localparam int unsigned PINS = 12;

	typedef struct packed {
		logic [SYNC_STAGES-1:0][PINS-1:0] sync;  // [0] first flop
		logic [PINS-1:0]                  pin;   // Agreed pin levels
		logic                             armed;
		logic                             sel;
		logic                             half;  // Upper nibble held
		logic [NIBBLE_WIDTH-1:0]          hi;
		logic [4:0]                       words; // Words captured
		logic                             en_low;
		logic [4:0]                       slot;  // Next latch slot
		logic [OUTPUTS-1:0]               data_latch;
		logic [OUTPUTS-1:0]               line_latch;
		logic [OUTPUTS-1:0]               shreg;
		logic                             out_first;
		logic                             out_second;
	} ldi_state_s;

	ldi_state_s st_q, st_d;

	logic [PINS-1:0]      raw;
	logic [PINS-1:0]      agree;
	logic                 xck_fall, lp_fall;
	logic [7:0]           din;
	logic                 en_in;
	logic                 take;
	logic [BUS_WIDTH-1:0] word;
	logic                 word_valid;
	logic                 push_ready;
	logic                 pop_valid;
	logic                 pop_ready;
	logic [BUS_WIDTH-1:0] pop_data;

	// Mirror a bus word so reversed fill keeps pixel order on the outputs
	function automatic logic [BUS_WIDTH-1:0] bit_rev(
		input logic [BUS_WIDTH-1:0] w
	);
		logic [BUS_WIDTH-1:0] r;
		r = '0;
		for (int i = 0; i < BUS_WIDTH; i++) begin
			r[i] = w[BUS_WIDTH-1-i];
		end
		return r;
	endfunction : bit_rev

	////////////////////////////////////////////////////////////////////
	// Pin sampling

	assign raw = {PIXEL_SHIFT_CLOCK, LINE_LATCH_PULSE, CASCADE_PORT_FIRST_I,
		CASCADE_PORT_SECOND_I, PIXEL_DATA_IN};

	// A change counts only when the second and third flops agree
	assign agree = ~(st_q.sync[1] ^ st_q.sync[2]);

	assign xck_fall = agree[11] & st_q.pin[11] & ~st_q.sync[2][11];
	assign lp_fall  = agree[10] & st_q.pin[10] & ~st_q.sync[2][10];
	assign din      = st_q.pin[7:0];
	// Input port of the cascade pair follows SHIFT_DIR
	assign en_in    = SHIFT_DIR ? st_q.pin[9] : st_q.pin[8];

	////////////////////////////////////////////////////////////////////
	// Segment capture and word assembly

	// Low enable-in while armed selects; selection holds until done
	assign take = SEG_MODE & xck_fall & push_ready
		& (st_q.sel | (st_q.armed & ~en_in));

	always_comb begin
		word       = din;
		word_valid = 1'b0;
		if (take) begin
			if (WIDTH_SELECT) begin
				word_valid = 1'b1;
			end else begin
				word       = {st_q.hi, din[NIBBLE_WIDTH-1:0]};
				word_valid = st_q.half;
			end
		end
	end

	// Drain stalls while the line latch is being loaded
	assign pop_ready = ~lp_fall;

	ldi_fifo #(
		.WIDTH (BUS_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (SYS_RST),
		.in_valid  (word_valid),
		.in_ready  (push_ready),
		.in_data   (word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_data)
	);

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d        = st_q;
		st_d.sync   = {st_q.sync[SYNC_STAGES-2:0], raw};
		for (int i = 0; i < PINS; i++) begin
			if (agree[i]) begin
				st_d.pin[i] = st_q.sync[2][i];
			end
		end

		// Enable pulse lasts from one pixel clock fall to the next
		if (xck_fall) begin
			st_d.en_low = 1'b0;
		end

		if (take) begin
			if (WIDTH_SELECT || st_q.half) begin
				st_d.half  = 1'b0;
				st_d.words = st_q.words + 5'h01;
				if (st_q.words == 5'(SLOTS - 1)) begin
					// Last word: hand enable on and drop out
					st_d.sel    = 1'b0;
					st_d.armed  = 1'b0;
					st_d.en_low = 1'b1;
				end else begin
					st_d.sel   = 1'b1;
					st_d.armed = 1'b0;
				end
			end else begin
				st_d.half = 1'b1;
				st_d.hi   = din[NIBBLE_WIDTH-1:0];
				st_d.sel  = 1'b1;
				st_d.armed = 1'b0;
			end
		end

		// Each bus word lands in the next slot along the shift direction
		if (pop_valid && pop_ready) begin
			if (SHIFT_DIR) begin
				st_d.data_latch[st_q.slot*BUS_WIDTH +: BUS_WIDTH] =
					bit_rev(pop_data);
			end else begin
				st_d.data_latch[(SLOTS-1-st_q.slot)*BUS_WIDTH +: BUS_WIDTH] =
					pop_data;
			end
			st_d.slot = st_q.slot + 5'h01;
		end

		if (lp_fall) begin
			if (SEG_MODE) begin
				// Whole line moves at once; control restarts for next line
				st_d.line_latch = st_q.data_latch;
				st_d.armed      = 1'b1;
				st_d.sel        = 1'b0;
				st_d.half       = 1'b0;
				st_d.words      = '0;
				st_d.slot       = SLOT_RESET;
				st_d.en_low     = 1'b0;
			end else begin
				// Index 0 is the first drive output
				unique case ({DUAL_MODE, SHIFT_DIR})
				2'b01: st_d.shreg = {st_q.shreg[OUTPUTS-2:0],
					st_q.pin[9]};
				2'b00: st_d.shreg = {st_q.pin[8],
					st_q.shreg[OUTPUTS-1:1]};
				2'b11: st_d.shreg = {st_q.shreg[OUTPUTS-2:HALF], din[7],
					st_q.shreg[HALF-2:0], st_q.pin[9]};
				2'b10: st_d.shreg = {st_q.pin[8], st_q.shreg[OUTPUTS-1:HALF+1],
					din[7], st_q.shreg[HALF-1:1]};
				endcase
			end
		end

		// Output levels for the cascade ports, registered
		st_d.out_first  = SEG_MODE ? ~st_d.en_low : st_d.shreg[0];
		st_d.out_second = SEG_MODE ? ~st_d.en_low : st_d.shreg[OUTPUTS-1];
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q            <= '0;
			st_q.out_first  <= ENABLE_IDLE;
			st_q.out_second <= ENABLE_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	// Low enable means the pin is driven
	assign CASCADE_PORT_FIRST_OE_N  = SHIFT_DIR;
	assign CASCADE_PORT_SECOND_OE_N = ~SHIFT_DIR;
	assign CASCADE_PORT_FIRST_O     = st_q.out_first;
	assign CASCADE_PORT_SECOND_O    = st_q.out_second;
	assign DRIVE_OUTPUTS = SEG_MODE ? st_q.line_latch : st_q.shreg;

endmodule : ldi_input

/* verif/ldi_input_sva.sv */
// Purpose: Port checks for the pixel input block
// Assumes: Pixel clock period between 8 and 40 CLK
// Notes:   Bound to every ldi_input instance
`timescale 1ns/1ns

module ldi_input_chk #(
	parameter int unsigned OUTPUTS = 160
) (
	input wire logic               CLK,
	input wire logic               SYS_RST,
	input wire logic               SEG_MODE,
	input wire logic               SHIFT_DIR,
	input wire logic               PIXEL_SHIFT_CLOCK,
	input wire logic               LINE_LATCH_PULSE,
	input wire logic               CASCADE_PORT_FIRST_O,
	input wire logic               CASCADE_PORT_FIRST_OE_N,
	input wire logic               CASCADE_PORT_SECOND_O,
	input wire logic               CASCADE_PORT_SECOND_OE_N,
	input wire logic [OUTPUTS-1:0] DRIVE_OUTPUTS
);
	logic eo;
	// Enable output is whichever port is not taking enable-in
	assign eo = SHIFT_DIR ? CASCADE_PORT_SECOND_O : CASCADE_PORT_FIRST_O;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Low for a whole pixel period, then back high in bounded time
	sequence low_phase; !eo [*8]; endsequence
	sequence back_high; ##[1:40] eo; endsequence
	////////////////////////////////////////////////////////////////////
	oe_first_a: assert property (CASCADE_PORT_FIRST_OE_N == SHIFT_DIR)
		else $error("first port direction wrong");
	oe_second_a: assert property (CASCADE_PORT_SECOND_OE_N != SHIFT_DIR)
		else $error("second port direction wrong");
	drive_latch_a: assert property (
		!$stable(DRIVE_OUTPUTS) |-> !LINE_LATCH_PULSE)
		else $error("outputs moved without latch pulse fall");
	en_fall_a: assert property (SEG_MODE && $fell(eo) |->
		$past(PIXEL_SHIFT_CLOCK, 2) == 1'b0)
		else $error("enable fell off clock");
	en_rise_a: assert property (SEG_MODE && $rose(eo) |->
		$past(PIXEL_SHIFT_CLOCK, 2) == 1'b0)
		else $error("enable rose off clock");
	en_low_a: assert property (SEG_MODE && $fell(eo) |-> low_phase)
		else $error("enable low too short");
	en_back_a: assert property (SEG_MODE && $fell(eo) |-> back_high)
		else $error("enable stuck low");
	end_first_a: assert property (!SEG_MODE && !$past(SYS_RST) &&
		$stable(DRIVE_OUTPUTS) |-> CASCADE_PORT_FIRST_O == DRIVE_OUTPUTS[0])
		else $error("first port not low end bit");
	end_second_a: assert property (!SEG_MODE && !$past(SYS_RST) &&
		$stable(DRIVE_OUTPUTS) |->
		CASCADE_PORT_SECOND_O == DRIVE_OUTPUTS[OUTPUTS-1])
		else $error("second port not high end bit");
endmodule : ldi_input_chk

bind ldi_input ldi_input_chk #(.OUTPUTS(OUTPUTS)) u_chk (
	.CLK(CLK), .SYS_RST(SYS_RST), .SEG_MODE(SEG_MODE),
	.SHIFT_DIR(SHIFT_DIR), .PIXEL_SHIFT_CLOCK(PIXEL_SHIFT_CLOCK),
	.LINE_LATCH_PULSE(LINE_LATCH_PULSE),
	.CASCADE_PORT_FIRST_O(CASCADE_PORT_FIRST_O),
	.CASCADE_PORT_FIRST_OE_N(CASCADE_PORT_FIRST_OE_N),
	.CASCADE_PORT_SECOND_O(CASCADE_PORT_SECOND_O),
	.CASCADE_PORT_SECOND_OE_N(CASCADE_PORT_SECOND_OE_N),
	.DRIVE_OUTPUTS(DRIVE_OUTPUTS)
);

/* verif/ldi_ctrl_model.sv */
// Purpose: Timing controller and neighbour chip ahead of the block
// Assumes: Pins change only on falling CLK edges
// Notes:   Released data lines show a changed value, not the old one
`timescale 1ns/1ns

module ldi_ctrl_model (
	input wire logic       clk,
	output logic           pixel_shift_clock,
	output logic           lp,
	output logic           cas,
	output logic     [7:0] data
);
	// Idle levels: clocks high and low, neighbour enable inactive
	initial begin
		pixel_shift_clock = 1'b1;
		lp = 1'b0;
		cas = 1'b1;
		data = 8'h00;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask : gap
	// Data stand five CLK either side of the fall, so late sampling shows
	task automatic word(input logic [7:0] d, input logic [7:0] m);
		@(negedge clk);
		data = d;
		gap(5);
		pixel_shift_clock = 1'b0;
		gap(5);
		pixel_shift_clock = 1'b1;
		data = d ^ m; // Unmasked bits stay tied in narrow mode
	endtask : word
	// Latch pulse; the shift clock in common mode
	task automatic latch;
		@(negedge clk);
		lp = 1'b1;
		gap(5);
		lp = 1'b0;
		gap(8);
	endtask : latch
endmodule : ldi_ctrl_model

/* verif/ldi_input_tb.sv */
// Purpose: Self-checking bench for the pixel input block
// Assumes: Pixel clock of 11 CLK, all straps set under reset
// Notes:   Both cascade wires resolved from the port enables
`timescale 1ns/1ns

module ldi_input_tb;
	logic         clk, rst, seg, dir, dual, w8, pixel_shift_clock, lp, cas;
	logic         p1, p2, o1, o2, oe1_n, oe2_n;
	logic [7:0]   di;
	logic [159:0] drv, exp;
	int           errors, total_checks, low_n, cyc;

	ldi_ctrl_model ctrl (.clk(clk), .pixel_shift_clock(pixel_shift_clock), .lp(lp), .cas(cas), .data(di));
	ldi_input DUT (
		.CLK(clk), .SYS_RST(rst), .SEG_MODE(seg), .SHIFT_DIR(dir),
		.DUAL_MODE(dual), .WIDTH_SELECT(w8), .PIXEL_SHIFT_CLOCK(pixel_shift_clock),
		.LINE_LATCH_PULSE(lp), .PIXEL_DATA_IN(di),
		.CASCADE_PORT_FIRST_I(p1), .CASCADE_PORT_FIRST_O(o1),
		.CASCADE_PORT_FIRST_OE_N(oe1_n), .CASCADE_PORT_SECOND_I(p2),
		.CASCADE_PORT_SECOND_O(o2), .CASCADE_PORT_SECOND_OE_N(oe2_n),
		.DRIVE_OUTPUTS(drv)
	);
	// Wire level: the driving side wins
	assign p1 = oe1_n ? cas : o1;
	assign p2 = oe2_n ? cas : o2;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Count enable-low cycles and cut a hang short; sampled on the
	// falling edge so the registered enable has settled
	always @(negedge clk) begin
		cyc++;
		if (!(dir ? o2 : o1)) low_n++;
		if (cyc == 5000) begin
			errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [159:0] got, input logic [159:0] e);
		total_checks++;
		if (got !== e) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, e);
		end
	endtask : chk
	task automatic restart(input logic s, d, du, w);
		@(negedge clk);
		rst = 1'b1;
		seg = s;
		dir = d;
		dual = du;
		w8 = w;
		ctrl.cas = s;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		low_n = 0;
	endtask : restart
	// One segment line: stray clock, arm, 20 words, two extra words
	task automatic seg_line(input logic d, input logic w);
		logic [7:0] wd;
		restart(1'b1, d, 1'b0, w);
		exp = '0;
		ctrl.word(8'hC3, 8'hFF);
		ctrl.latch();
		// Armed but enable-in still high: this word must be refused
		ctrl.word(8'h3C, 8'hFF);
		ctrl.cas = 1'b0;
		for (int k = 0; k < 22; k++) begin
			wd = (k < 20) ? 8'(k * 8'h1D + 8'h5A) : 8'hFF;
			if (w) ctrl.word(wd, 8'hFF);
			else begin
				ctrl.word({4'hA, wd[7:4]}, 8'h0F);
				ctrl.word({4'hA, wd[3:0]}, 8'h0F);
			end
			ctrl.cas = 1'b1;
			for (int j = 0; j < 8; j++)
				if (k < 20) exp[d ? 8*k+j : 159-8*k-j] = wd[7-j];
		end
		ctrl.gap(6);
		ctrl.latch();
		chk(drv, exp);
		chk(160'(low_n), 160'h0B);
	endtask : seg_line
	// Common mode: eight shifts in one direction setting
	task automatic shift_run(input logic d, du, input logic [7:0] a, b,
		input logic [159:0] e);
		restart(1'b0, d, du, 1'b0);
		for (int i = 0; i < 8; i++) begin
			ctrl.cas = d ? a[7-i] : a[i];
			ctrl.data = {d ? b[7-i] : b[i], 7'h00};
			ctrl.latch();
		end
		chk(drv, e);
		chk({158'h0, oe2_n, oe1_n}, {158'h0, ~d, d});
	endtask : shift_run
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		seg = 1'b1;
		dir = 1'b1;
		dual = 1'b0;
		w8 = 1'b1;
		seg_line(1'b1, 1'b1);
		seg_line(1'b0, 1'b0);
		shift_run(1'b1, 1'b0, 8'hB4, 8'h00, 160'hB4);
		shift_run(1'b0, 1'b0, 8'hB4, 8'h00, {8'hB4, 152'h0});
		shift_run(1'b1, 1'b1, 8'h6D, 8'h93, {72'h0, 8'h93, 72'h0, 8'h6D});
		shift_run(1'b0, 1'b1, 8'h6D, 8'h93, {8'h6D, 72'h0, 8'h93, 72'h0});
		close_out();
	end
endmodule : ldi_input_tb
